// ===== shared/emid_pkg.sv
// constants, register map and helpers of the e.MMC identity register set
`default_nettype none
package emid_pkg;
   // ----------------------------------------------------------------
   // register byte offsets on the apb bus
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_OPC    = 8'h00;
   localparam logic [7:0] ADDR_IDT0   = 8'h04;
   localparam logic [7:0] ADDR_SPD0   = 8'h14;
   localparam logic [7:0] ADDR_DRV    = 8'h24;
   localparam logic [7:0] ADDR_SERIAL = 8'h28;
   localparam logic [7:0] ADDR_MFD    = 8'h2c;
   localparam logic [7:0] ADDR_STATUS = 8'h30;
   localparam int         IDT_WORDS   = 4;

   // ----------------------------------------------------------------
   // field values
   // ----------------------------------------------------------------
   localparam logic [8:0]  OPC_HIGH_V    = 9'h1ff;
   localparam logic [6:0]  OPC_MID_V     = 7'h00;
   localparam logic        OPC_LOW_V     = 1'b1;
   localparam logic        OPC_SECTOR    = 1'b1;
   localparam logic [15:0] DRV_VALUE     = 16'h0404;
   localparam logic [1:0]  SPD_STRUCT    = 2'h3;
   localparam logic [3:0]  SPD_STD_VERS  = 4'h4;
   localparam logic [7:0]  SPD_ACC1      = 8'h0f;
   localparam logic [7:0]  SPD_ACC2      = 8'h00;
   localparam logic [31:0] SERIAL_RESET  = 32'h0000_0000;
   localparam logic [7:0]  MFD_RESET     = 8'h11;
   localparam logic [6:0]  CRC7_POLY     = 7'h09;

   // ----------------------------------------------------------------
   // timing and link framing
   // ----------------------------------------------------------------
   localparam int          CLK_SYS_NS   = 40;
   localparam int          INIT_TIME_NS = 1000;
   localparam int          INIT_CYCLES  = (INIT_TIME_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
   localparam int          CMD_BITS     = 48;
   localparam logic [5:0]  NCR_CYCLES   = 6'h02;
   localparam logic [5:0]  CMD_OP_COND  = 6'h01;

   // register selects
   typedef enum logic [3:0] {
      EMID_OPC, EMID_IDT, EMID_SPD, EMID_DRV, EMID_SERIAL, EMID_MFD, EMID_STATUS,
      EMID_NONE
   } emid_reg_e;

   // crc7 over the 120 upper identity bits, msb first
   function automatic logic [6:0] emid_crc7(input logic [119:0] data);
      logic [6:0] crc;
      logic       fb;
      crc = 7'h00;
      for (int i = 119; i >= 0; i--) begin
         fb  = data[i] ^ crc[6];
         crc = {crc[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
      end
      return crc;
   endfunction : emid_crc7
endpackage : emid_pkg
`default_nettype wire

// ===== shared/emid_link_if.sv
// signals passing between the system side and the link side
`default_nettype none
interface emid_link_if;
   logic       ready;     // level, system clock domain
   logic       evt_tgl;   // toggles once per command, link domain
   logic [5:0] cmd_idx;   // updated on the same link edge as evt_tgl toggles

   modport sys  (output ready, input evt_tgl, input cmd_idx);
   modport link (input ready, output evt_tgl, output cmd_idx);
endinterface : emid_link_if
`default_nettype wire

// ===== hw/emid_link.sv
// link side: command receive and operating conditions response on the host clock
`default_nettype none
module emid_link (
   // link clock and system reset
   input  wire logic       clk_link,
   input  wire logic       rstn,
   // command pin
   input  wire logic       cmd_in,
   output logic            cmd_out,
   output logic            cmd_oe,
   // system side
   emid_link_if.link       lk
);
   typedef enum logic [1:0] {EMID_L_IDLE, EMID_L_RECV, EMID_L_GAP, EMID_L_RESP} emid_lst_e;
   typedef struct packed {
      logic       rs1, rs2, rd1, rd2;
      emid_lst_e  st;
      logic [5:0] cnt;
      logic [47:0] sh;
      logic       tgl;
      logic [5:0] idx;
      logic       co, oe;
   } emid_link_s;

   emid_link_s r, next_r;
   logic [47:0] frame;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r     = r;
      next_r.rs1 = rstn;      // reset and ready cross on two flops each
      next_r.rs2 = r.rs1;
      next_r.rd1 = lk.ready;
      next_r.rd2 = r.rd1;
      frame      = {r.sh[46:0], cmd_in};
      case (r.st)
         EMID_L_IDLE: begin
            next_r.oe = 1'b0;
            if (!cmd_in) begin                  // start bit
               next_r.sh  = {47'h0, cmd_in};
               next_r.cnt = 6'h01;
               next_r.st  = EMID_L_RECV;
            end
         end
         EMID_L_RECV: begin
            next_r.sh  = frame;                 // one bit per clock
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == 6'(emid_pkg::CMD_BITS - 1)) begin
               next_r.idx = frame[45:40];
               next_r.tgl = ~r.tgl;
               next_r.cnt = 6'h00;
               next_r.st  = (frame[45:40] == emid_pkg::CMD_OP_COND) ? EMID_L_GAP : EMID_L_IDLE;
            end
         end
         EMID_L_GAP: begin
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == emid_pkg::NCR_CYCLES - 6'h01) begin
               // response frame carries the operating conditions word
               next_r.sh  = {2'b00, 6'h3f, r.rd2, emid_pkg::OPC_SECTOR, 6'h00,
                             emid_pkg::OPC_HIGH_V, emid_pkg::OPC_MID_V,
                             emid_pkg::OPC_LOW_V, 7'h00, 7'h7f, 1'b1};
               next_r.cnt = 6'h00;
               next_r.st  = EMID_L_RESP;
            end
         end
         EMID_L_RESP: begin
            next_r.co  = r.sh[47];              // one bit per clock out
            next_r.oe  = 1'b1;
            next_r.sh  = {r.sh[46:0], 1'b1};
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == 6'(emid_pkg::CMD_BITS - 1)) begin
               next_r.st = EMID_L_IDLE;         // last bit driven next cycle, line released the cycle after
            end
         end
         default: next_r.st = EMID_L_IDLE;
      endcase
      if (!r.rs2) begin
         next_r.st  = EMID_L_IDLE;
         next_r.cnt = 6'h00;
         next_r.oe  = 1'b0;
         next_r.co  = 1'b1;
         next_r.tgl = 1'b0;   // a known toggle level, or no event ever crosses
         next_r.idx = 6'h00;
      end
   end

   // state register
   always_ff @(posedge clk_link) begin
      r <= next_r;
   end

   assign cmd_out    = r.co;
   assign cmd_oe     = r.oe;
   assign lk.evt_tgl = r.tgl;
   assign lk.cmd_idx = r.idx;
endmodule : emid_link
`default_nettype wire

// ===== hw/emid_regs.sv
// identity register set top: apb slave, identity words, e.MMC pins
`default_nettype none
module emid_regs #(
   // identity fields, values arbitrary
   parameter logic [7:0]  MFR_CODE   = 8'h5a,
   parameter logic [1:0]  PKG_TYPE   = 2'h2,
   parameter logic [7:0]  OEM_CODE   = 8'h3c,
   parameter logic [47:0] PROD_NAME  = 48'h4142_4344_4546,
   parameter logic [7:0]  PROD_REV   = 8'h27
) (
   // system clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // link clock and command line
   input  wire logic        clk_link,
   input  wire logic        cmd_in,
   output logic             cmd_out,
   output logic             cmd_oe,
   // data lines
   input  wire logic [7:0]  dat_in,
   output logic [7:0]       dat_out,
   output logic [7:0]       dat_oe,
   // hardware reset pin and data strobe
   input  wire logic        hw_rstn_pin,
   output logic             strobe_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        hwr1;
      logic        hwr2;
      logic [7:0]  init_cnt;
      logic        ready;
      logic [31:0] serial;
      logic [7:0]  mfd;
      logic        tg1;
      logic        tg2;
      logic        tgd;
      logic [5:0]  last_idx;
      logic [7:0]  cmd_cnt;
      logic        dat_seen;
      logic [15:0] dat_sync;
      logic [31:0] rdata;
      logic        err;
   } emid_sys_s;

   emid_sys_s    r;
   emid_sys_s    next_r;
   emid_link_if  lk ();

   logic [119:0]        idt_body;
   logic [127:0]        idt;
   logic [127:0]        spd;
   logic [31:0]         opc;
   emid_pkg::emid_reg_e sel;
   logic [1:0]          word;
   logic                setup;
   logic                wr_acc;

   // ----------------------------------------------------------------
   // address decode, used by read capture and write paths
   // ----------------------------------------------------------------
   function automatic emid_pkg::emid_reg_e emid_decode(input logic [7:0] a);
      emid_pkg::emid_reg_e s;
      s = emid_pkg::EMID_NONE;
      if (a[1:0] != 2'b00) begin
         s = emid_pkg::EMID_NONE;
      end else if (a == emid_pkg::ADDR_OPC) begin
         s = emid_pkg::EMID_OPC;
      end else if (a >= emid_pkg::ADDR_IDT0 && a < emid_pkg::ADDR_SPD0) begin
         s = emid_pkg::EMID_IDT;
      end else if (a >= emid_pkg::ADDR_SPD0 && a < emid_pkg::ADDR_DRV) begin
         s = emid_pkg::EMID_SPD;
      end else if (a == emid_pkg::ADDR_DRV) begin
         s = emid_pkg::EMID_DRV;
      end else if (a == emid_pkg::ADDR_SERIAL) begin
         s = emid_pkg::EMID_SERIAL;
      end else if (a == emid_pkg::ADDR_MFD) begin
         s = emid_pkg::EMID_MFD;
      end else if (a == emid_pkg::ADDR_STATUS) begin
         s = emid_pkg::EMID_STATUS;
      end
      return s;
   endfunction : emid_decode

   // word index inside a 128-bit register, low word at the base offset
   function automatic logic [1:0] emid_word(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      return d[3:2];
   endfunction : emid_word

   // ----------------------------------------------------------------
   // identity words
   // ----------------------------------------------------------------
   // operating conditions: ready only after init, fixed supply windows
   assign opc = {r.ready,
                 emid_pkg::OPC_SECTOR,
                 6'h00,
                 emid_pkg::OPC_HIGH_V,
                 emid_pkg::OPC_MID_V,
                 emid_pkg::OPC_LOW_V,
                 7'h00};

   // card identity: fields, then crc7 and a fixed stop bit
   assign idt_body = {MFR_CODE, 6'h00, PKG_TYPE, OEM_CODE, PROD_NAME, PROD_REV,
                      r.serial,
                      r.mfd};                     // month high nibble, year low
   assign idt      = {idt_body, emid_pkg::emid_crc7(idt_body), 1'b1};

   // card specific data: structure, version and access times
   assign spd = {emid_pkg::SPD_STRUCT, emid_pkg::SPD_STD_VERS, 2'b00,
                 emid_pkg::SPD_ACC1,
                 emid_pkg::SPD_ACC2,
                 103'h0, 1'b1};

   // ----------------------------------------------------------------
   // bus phase decode
   // ----------------------------------------------------------------
   // read data is captured in setup, so the slave never needs a wait state
   assign setup  = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign sel    = emid_decode(paddr);
   always_comb begin
      word = 2'b00;
      if (sel == emid_pkg::EMID_IDT) begin
         word = emid_word(paddr, emid_pkg::ADDR_IDT0);
      end else if (sel == emid_pkg::EMID_SPD) begin
         word = emid_word(paddr, emid_pkg::ADDR_SPD0);
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;

      // hardware reset pin passes two flops before use
      next_r.hwr1 = hw_rstn_pin;
      next_r.hwr2 = r.hwr1;

      // power-up initialisation; pin reset restarts it
      if (!r.hwr2) begin
         next_r.ready    = 1'b0;
         next_r.init_cnt = 8'h00;
      end else if (!r.ready) begin
         if (r.init_cnt == 8'(emid_pkg::INIT_CYCLES - 1)) begin
            next_r.ready = 1'b1;
         end else begin
            next_r.init_cnt = r.init_cnt + 8'h01;
         end
      end

      // command event from the link domain by toggle; index already stable
      next_r.tg1 = lk.evt_tgl;
      next_r.tg2 = r.tg1;
      next_r.tgd = r.tg2;
      if (r.tg2 != r.tgd) begin
         next_r.last_idx = lk.cmd_idx;
         next_r.cmd_cnt  = r.cmd_cnt + 8'h01;
      end

      // data pins pass two flops first; reads would drive them
      next_r.dat_sync = {r.dat_sync[7:0], dat_in};
      if (r.dat_sync[15:8] != 8'hff) begin
         next_r.dat_seen = 1'b1;
      end

      // read capture during the setup cycle
      if (setup) begin
         next_r.err = (sel == emid_pkg::EMID_NONE);
         case (sel)
            emid_pkg::EMID_OPC:    next_r.rdata = opc;
            emid_pkg::EMID_IDT:    next_r.rdata = idt[32*word +: 32];
            emid_pkg::EMID_SPD:    next_r.rdata = spd[32*word +: 32];
            emid_pkg::EMID_DRV:    next_r.rdata = {16'h0000, emid_pkg::DRV_VALUE};
            emid_pkg::EMID_SERIAL: next_r.rdata = r.serial;
            emid_pkg::EMID_MFD:    next_r.rdata = {24'h00_0000, r.mfd};
            emid_pkg::EMID_STATUS: next_r.rdata = {14'h0000, r.dat_seen, r.ready,
                                                   r.cmd_cnt, 2'b00, r.last_idx};
            default:               next_r.rdata = 32'h0000_0000;
         endcase
      end

      // writes take effect at the access edge; read-only words ignore them
      if (wr_acc) begin
         if (sel == emid_pkg::EMID_SERIAL) begin
            for (int b = 0; b < 4; b++) begin
               if (pstrb[b]) begin
                  next_r.serial[8*b +: 8] = pwdata[8*b +: 8];
               end
            end
         end else if (sel == emid_pkg::EMID_MFD && pstrb[0]) begin
            next_r.mfd = pwdata[7:0];
         end
         // driver stage word: write is accepted and dropped
      end

      // synchronous reset; sync flops keep sampling
      if (!rstn) begin
         next_r.init_cnt = 8'h00;
         next_r.ready    = 1'b0;
         next_r.serial   = emid_pkg::SERIAL_RESET;
         next_r.mfd      = emid_pkg::MFD_RESET;
         next_r.tgd      = r.tg2;
         next_r.last_idx = 6'h00;
         next_r.cmd_cnt  = 8'h00;
         next_r.dat_seen = 1'b0;
         next_r.rdata    = 32'h0000_0000;
         next_r.err      = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      r <= next_r;
   end

   // ----------------------------------------------------------------
   // link side
   // ----------------------------------------------------------------
   assign lk.ready = r.ready;

   emid_link u_link (
      .clk_link (clk_link),
      .rstn     (rstn),
      .cmd_in   (cmd_in),
      .cmd_out  (cmd_out),
      .cmd_oe   (cmd_oe),
      .lk       (lk)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign pready     = psel & penable;
   assign prdata     = r.rdata;
   assign pslverr    = psel & penable & r.err;
   // no data reads in this block: host owns the data lines
   assign dat_out    = 8'hff;
   assign dat_oe     = 8'h00;
   // strobe only runs in the fast double-rate mode, not served here
   assign strobe_out = 1'b0;
endmodule : emid_regs
`default_nettype wire

// ===== testbench/emid_host_model.sv
// host controller model: link clock and command line of the e.MMC bus
`default_nettype none
module emid_host_model (
   // link clock and command line
   output var logic  clk_link,
   output wire logic cmd_in,
   input  wire logic cmd_out,
   input  wire logic cmd_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic h_oe  = 1'b0;
   logic h_bit = 1'b1;
   initial clk_link = 1'b0;

   // ---------------------------------------------------------------
   // wire level
   // ---------------------------------------------------------------
   // a released line floats high through its pull-up
   assign cmd_in = h_oe ? h_bit : (cmd_oe ? cmd_out : 1'b1);

   // crc7 of the n low bits of d, msb first
   function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
      logic [6:0] c;
      logic       f;
      c = 7'h00;
      for (int i = n - 1; i >= 0; i--) begin
         f = d[i] ^ c[6];
         c = {c[5:0], 1'b0} ^ (f ? 7'h09 : 7'h00);
      end
      return c;
   endfunction : crc7

   // one link cycle; the next bit changes just after the rising edge
   task automatic tick(input logic oe, input logic b);
      clk_link = 1'b1;
      h_oe    <= oe;
      h_bit   <= b;
      #62.5 clk_link = 1'b0;
      #62.5;
   endtask : tick

   // idle cycles; the clock otherwise stands still outside frames
   task automatic run(input int n);
      repeat (n) tick(1'b0, 1'b1);
   endtask : run

   // send one command frame, then collect 48 response bits whether or not one starts
   task automatic command(input logic [5:0] idx, input logic [31:0] arg,
                          output logic [47:0] rsp, output logic seen);
      logic [47:0] f;
      int          n;
      f      = {2'b01, idx, arg, 8'h01};
      f[7:1] = crc7({80'h0, f[47:8]}, 40);
      #7;  // keeps link edges apart from system edges
      h_oe  = 1'b1;
      h_bit = f[47];
      for (int i = 46; i >= 0; i--) tick(1'b1, f[i]);
      tick(1'b0, 1'b1);
      n = 0;
      while (cmd_in !== 1'b0 && n < 8) begin
         tick(1'b0, 1'b1);
         n++;
      end
      seen = (n < 8);
      for (int i = 47; i >= 0; i--) begin
         rsp[i] = cmd_in;
         tick(1'b0, 1'b1);
      end
      run(2);
   endtask : command
endmodule : emid_host_model
`default_nettype wire

// ===== testbench/emid_regs_chk.sv
// concurrent checks on the ports of the identity register set
`default_nettype none
module emid_regs_chk (
   // system side
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        hw_rstn_pin,
   // link side
   input wire logic        clk_link,
   input wire logic        cmd_out,
   input wire logic        cmd_oe,
   input wire logic [7:0]  dat_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] init_cnt;  // system cycles since the last reset release
   logic [5:0] oe_cnt;    // link cycles the response line is driven

   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   // saturates so a long run never wraps back into the init window
   always_ff @(posedge clk_sys) begin
      if (!rstn || !hw_rstn_pin) init_cnt <= 6'd0;
      else if (init_cnt != 6'd63) init_cnt <= init_cnt + 6'd1;
   end
   always_ff @(posedge clk_link) begin
      if (!rstn) oe_cnt <= 6'd0;
      else oe_cnt <= cmd_oe ? oe_cnt + 6'd1 : 6'd0;
   end

   // ---------------------------------------------------------------
   // sequences and assertions
   // ---------------------------------------------------------------
   sequence rd_at(logic [7:0] a);
      psel && penable && !pwrite && paddr == a;
   endsequence
   sequence rsp_head;
      !cmd_out ##1 (cmd_oe && !cmd_out);
   endsequence

   ready_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (psel && !penable) ##1 penable |-> pready) else $error("access without ready");
   err_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      pslverr |-> psel && penable) else $error("error outside access");
   err_unmapped_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      psel && penable && (paddr > 8'h30 || paddr[1:0] != 2'b00) |-> pslverr)
      else $error("unmapped access accepted");
   opc_high_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_at(8'h00) |-> prdata[23:15] == 9'h1ff) else $error("high window bits");
   opc_mid_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_at(8'h00) |-> prdata[14:8] == 7'h00) else $error("mid range bits");
   opc_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_at(8'h00) |-> prdata[7]) else $error("low range bit");
   opc_sector_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_at(8'h00) |-> prdata[30]) else $error("capacity bit");
   opc_init_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_at(8'h00) ##0 init_cnt < 6'd20 |-> !prdata[31]) else $error("ready too early");
   opc_ready_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_at(8'h00) ##0 init_cnt > 6'd30 |-> prdata[31]) else $error("ready too late");
   drv_fixed_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_at(8'h24) |-> prdata == 32'h0000_0404) else $error("driver stage value");
   spd_acc1_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_at(8'h20) |-> prdata[23:16] == 8'h0f) else $error("access time one");
   spd_acc2_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_at(8'h20) |-> prdata[15:8] == 8'h00) else $error("access time two");
   idt_end_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_at(8'h04) |-> prdata[0]) else $error("identity end bit");
   rsp_head_a: assert property (@(posedge clk_link) disable iff (!rstn)
      $rose(cmd_oe) |-> rsp_head) else $error("response header");
   rsp_len_a: assert property (@(posedge clk_link) disable iff (!rstn)
      $fell(cmd_oe) |-> oe_cnt == 6'd48) else $error("response length");
   cmd_idle_a: assert property (@(posedge clk_link) disable iff (!rstn)
      !cmd_oe |-> cmd_out) else $error("command line idle level");
   dat_quiet_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      dat_oe == 8'h00) else $error("data lines driven");
endmodule : emid_regs_chk

bind emid_regs emid_regs_chk u_chk (
   .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .hw_rstn_pin(hw_rstn_pin), .clk_link(clk_link), .cmd_out(cmd_out),
   .cmd_oe(cmd_oe), .dat_oe(dat_oe)
);
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench of the identity register set
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0]  T_MFR  = 8'h96;             // arbitrary maker code
   localparam logic [47:0] T_NAME = 48'h5445_5354_4e4d; // arbitrary product name
   logic        clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, dat_in = 8'hff;
   logic [31:0] pwdata = 32'h0, prdata, serial_m = 32'h0;
   logic        pready, pslverr, cmd_out, cmd_oe, strobe_out, hw_rstn_pin = 1'b1;
   logic [7:0]  dat_out, dat_oe, mfd_m = 8'h11, cnt_m = 8'h00;
   logic        ready_m = 1'b0, dseen_m = 1'b0;
   logic [5:0]  idx_m = 6'h00;
   wire logic   clk_link, cmd_in;
   int          n_fail = 0, comparisons = 0, cycles = 0;

   emid_regs #(.MFR_CODE(T_MFR), .PKG_TYPE(2'h2), .OEM_CODE(8'h5c), .PROD_NAME(T_NAME),
      .PROD_REV(8'h27)) dut (
      .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clk_link(clk_link), .cmd_in(cmd_in), .cmd_out(cmd_out),
      .cmd_oe(cmd_oe), .dat_in(dat_in), .dat_out(dat_out), .dat_oe(dat_oe),
      .hw_rstn_pin(hw_rstn_pin), .strobe_out(strobe_out));
   emid_host_model host (.clk_link(clk_link), .cmd_in(cmd_in), .cmd_out(cmd_out),
      .cmd_oe(cmd_oe));

   // ---------------------------------------------------------------
   // clock, timeout and reporting
   // ---------------------------------------------------------------
   always #20 clk_sys = ~clk_sys;
   // a hung handshake ends here rather than stalling the run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [63:0] s, input logic [63:0] x);
      comparisons++;
      if (s !== x) begin
         n_fail++;
         $display("wrong value at %0t: saw %h expected %h", $time, s, x);
      end
   endtask : chk

   // ---------------------------------------------------------------
   // behavioural register model
   // ---------------------------------------------------------------
   function automatic logic [31:0] model_rd(input logic [7:0] a);
      logic [119:0] u;
      logic [127:0] idt, spd;
      u   = {T_MFR, 6'h0, 2'h2, 8'h5c, T_NAME, 8'h27, serial_m, mfd_m};
      idt = {u, host.crc7(u, 120), 1'b1};
      spd = {2'h3, 4'h4, 2'h0, 8'h0f, 8'h00, 103'h0, 1'b1};
      case (a)
         8'h00: return {ready_m, 1'b1, 6'h00, 9'h1ff, 7'h00, 1'b1, 7'h00};
         8'h04, 8'h08, 8'h0c, 8'h10: return idt[(a - 8'h04) * 8 +: 32];
         8'h14, 8'h18, 8'h1c, 8'h20: return spd[(a - 8'h14) * 8 +: 32];
         8'h24: return 32'h0000_0404;
         8'h28: return serial_m;
         8'h2c: return {24'h0, mfd_m};
         8'h30: return {14'h0, dseen_m, ready_m, cnt_m, 2'h0, idx_m};
         default: return 32'h0000_0000;
      endcase
   endfunction : model_rd

   // one apb transfer; waits for pready, only the timeout ends a hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic check_rd(input logic [7:0] a);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk({32'h0, r}, {32'h0, model_rd(a)});
      chk({63'h0, e}, {63'h0, !(a[1:0] == 2'b00 && a <= 8'h30)});
   endtask : check_rd

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] d, r;
      logic [47:0] rsp;
      logic        e, seen;
      void'($urandom(32'hc0b5));
      // reset must span enough link edges as well
      fork
         repeat (13) @(posedge clk_sys);
         host.run(4);
      join
      @(posedge clk_sys) rstn <= 1'b1;
      check_rd(8'h00);
      repeat (30) @(posedge clk_sys);
      ready_m = 1'b1;
      // second pass writes random data to each address just before reading it back
      for (int p = 0; p < 2; p++) begin
         for (int a = 0; a <= 8'h34; a += 4) begin
            if (p == 1) begin
               d = $urandom;
               apb(1'b1, 8'(a), d, r, e);
               if (a == 8'h28) serial_m = d;
               if (a == 8'h2c) mfd_m = d[7:0];
            end
            check_rd(8'(a));
         end
      end
      apb(1'b1, 8'h2d, 32'hffff_ffff, r, e);
      check_rd(8'h2c);
      check_rd(8'h02);
      // hardware reset pin restarts initialisation
      hw_rstn_pin <= 1'b0;
      ready_m = 1'b0;
      repeat (8) @(posedge clk_sys);
      check_rd(8'h00);
      hw_rstn_pin <= 1'b1;
      check_rd(8'h00);
      repeat (40) @(posedge clk_sys);
      ready_m = 1'b1;
      check_rd(8'h00);
      // host pulls a data line low while writing
      dat_in  <= 8'($urandom) & 8'hfe;
      dseen_m = 1'b1;
      host.run(3);  // link reset sync needs edges after release
      host.command(6'h01, $urandom, rsp, seen);
      chk({63'h0, seen}, 64'h1);
      chk({16'h0, rsp}, {16'h0, 2'b00, 6'h3f, model_rd(8'h00), 8'hff});
      host.command(6'h02, 32'h0, rsp, seen);
      chk({63'h0, seen}, 64'h0);
      cnt_m = 8'h02;
      idx_m = 6'h02;
      repeat (10) @(posedge clk_sys);
      check_rd(8'h30);
      chk({47'h0, strobe_out, dat_out, dat_oe}, 64'hff00);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
